/* rtl/fbsr_top.sv */
// four-bit shift register with j/k first stage behind an axi4-lite slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "fbsr_consts.svh"
module fbsr_top
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // stage clock and clear from surrounding logic
    input wire logic stage_clk,
    input wire logic stage_clear,
    // load/shift and true/complement selects
    input wire logic load_sel,
    input wire logic true_sel,
    // parallel and serial data
    input wire logic [3:0] par_in,
    input wire logic serial_set,
    input wire logic serial_hold_n,
    // stage outputs
    output logic [3:0] stage_out,
    output logic first_stage_out,
    output logic last_stage_out,
    // output word stream, one word per stage step, from a pin or software edge
    output logic word_valid,
    input wire logic word_ready,
    output logic [3:0] word_data,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // shared decode
    // ==========================================================

    // first stage next value from set and inverted-sense hold
    function automatic logic jk_next(input logic s, input logic hn,
                                     input logic q);
        fbsr_pkg::fbsr_jk_e code;
        begin
            code = fbsr_pkg::fbsr_jk_e'({s, hn});
            case (code)
                fbsr_pkg::FBSR_JK_HOLD: jk_next = q;
                fbsr_pkg::FBSR_JK_CLR: jk_next = 1'b0;
                fbsr_pkg::FBSR_JK_SET: jk_next = 1'b1;
                fbsr_pkg::FBSR_JK_TOG: jk_next = ~q;
                default: jk_next = q;
            endcase
        end
    endfunction

    // presented value under true/complement select
    function automatic logic [3:0] present(input logic [3:0] q,
                                           input logic t);
        present = t ? q : ~q;
    endfunction

    // ==========================================================
    // control register and source selects
    // ==========================================================
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [3:0] spar_r, spar_nxt;
    logic sw_edge_r, sw_edge_nxt;
    logic eff_load, eff_true, eff_clear, edge_hit;
    logic clk_d_r, clk_d_nxt;

    // pins and software both steer the register
    always_comb
    begin
        eff_load = load_sel | ctrl_r[`FBSR_CTRL_LOAD];
        eff_true = true_sel & ctrl_r[`FBSR_CTRL_TRUE];
        eff_clear = stage_clear | ctrl_r[`FBSR_CTRL_CLEAR];
        edge_hit = (stage_clk & ~clk_d_r) | sw_edge_r;
        clk_d_nxt = stage_clk;
    end

    // previous sample of the stage clock pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_d_r <= 1'b0;
        end
        else
        begin
            clk_d_r <= clk_d_nxt;
        end
    end

    // ==========================================================
    // stage register
    // ==========================================================
    fbsr_pkg::fbsr_stage_t stage_r, stage_nxt;
    fbsr_buf_if word_if();

    // next stage contents
    always_comb
    begin
        stage_nxt = stage_r;
        if (eff_clear)
            stage_nxt = 4'h0;
        else if (edge_hit && word_if.ready)
        begin
            if (eff_load)
                stage_nxt = eff_load ? (sw_edge_r ? spar_r : par_in)
                                     : stage_r;
            else
                stage_nxt = {stage_r[2:0],
                             jk_next(serial_set, serial_hold_n,
                                     stage_r[0])};
        end
    end

    // stage flip-flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage_r <= 4'h0;
        end
        else
        begin
            stage_r <= stage_nxt;
        end
    end

    // push each stepped word into the buffer
    assign word_if.valid = edge_hit && !eff_clear;
    assign word_if.data = present(stage_nxt, eff_true);

    fbsr_skid u_skid
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_if(word_if),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // output registers, stored value untouched by select
    logic [3:0] out_r, out_nxt;
    always_comb
    begin
        out_nxt = present(stage_nxt, eff_true);
    end

    // presented outputs, cleared stages shown true after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_r <= 4'h0;
        end
        else
        begin
            out_r <= out_nxt;
        end
    end

    // ==========================================================
    // axi4-lite slave
    // ==========================================================
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wen_r, wen_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic arready_r, arready_nxt;

    // write and read channel handling
    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wen_nxt = wen_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        spar_nxt = spar_r;
        sw_edge_nxt = 1'b0;
        // take address and data in either order
        if (s_axi_awvalid && awready_r)
        begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wen_nxt = s_axi_wstrb[0]; // all fields sit in the low byte
        end
        // commit once address and data are both held
        if (aw_got_r && w_got_r && !bvalid_r)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `FBSR_RESP_OKAY;
            case (awaddr_r)
                `FBSR_ADDR_CTRL:
                begin
                    if (wen_r)
                        ctrl_nxt = wdata_r[2:0];
                end
                `FBSR_ADDR_PAR:
                begin
                    if (wen_r)
                    begin
                        spar_nxt = wdata_r[3:0];
                        sw_edge_nxt = 1'b1; // software clock edge
                    end
                end
                `FBSR_ADDR_STAT: bresp_nxt = `FBSR_RESP_OKAY;
                default: bresp_nxt = `FBSR_RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        // answer a read from the decoded register
        if (s_axi_arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `FBSR_RESP_OKAY;
            case (s_axi_araddr)
                `FBSR_ADDR_CTRL: rdata_nxt = {29'h0, ctrl_r};
                `FBSR_ADDR_PAR: rdata_nxt = {28'h0, spar_r};
                `FBSR_ADDR_STAT:
                    rdata_nxt = {27'h0, word_valid, stage_r};
                `FBSR_ADDR_STREAM: rdata_nxt = {28'h0, out_r};
                default:
                begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `FBSR_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        // ready again once the channel is free
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt = !w_got_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // ==========================================================
    // registers
    // ==========================================================

    // bus side state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= `FBSR_CTRL_RST;
            spar_r <= 4'h0;
            sw_edge_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0;
            wen_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            spar_r <= spar_nxt;
            sw_edge_r <= sw_edge_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wen_r <= wen_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    // ports straight from flip-flops
    assign stage_out = out_r;
    assign first_stage_out = out_r[0];
    assign last_stage_out = out_r[3];
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
endmodule // fbsr_top
`default_nettype wire

/* rtl/fbsr_consts.svh */
// constants for the four-bit parallel-in/parallel-out shift register
`ifndef FBSR_CONSTS_SVH
`define FBSR_CONSTS_SVH
`define FBSR_ADDR_CTRL 12'h000
`define FBSR_ADDR_PAR 12'h004
`define FBSR_ADDR_STAT 12'h008
`define FBSR_ADDR_STREAM 12'h00c
`define FBSR_CTRL_LOAD 0
`define FBSR_CTRL_TRUE 1
`define FBSR_CTRL_CLEAR 2
`define FBSR_CTRL_RST 3'h2
`define FBSR_RESP_OKAY 2'h0
`define FBSR_RESP_SLVERR 2'h2
`define FBSR_STAT_VALID 4
`endif

/* rtl/fbsr_pkg.sv */
// types shared by the shift register design files
package fbsr_pkg;
    typedef logic [3:0] fbsr_stage_t;
    typedef enum logic [1:0] {
        FBSR_JK_HOLD = 2'h1,
        FBSR_JK_CLR = 2'h0,
        FBSR_JK_SET = 2'h3,
        FBSR_JK_TOG = 2'h2
    } fbsr_jk_e;
endpackage

/* rtl/fbsr_buf_if.sv */
// valid/ready carrier between the core and its output buffer
`timescale 1ns/1ns
`default_nettype none
interface fbsr_buf_if;
    logic valid;
    logic ready;
    logic [3:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/fbsr_skid.sv */
// two-entry valid/ready buffer for output words
`timescale 1ns/1ns
`default_nettype none
module fbsr_skid
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filling side
    fbsr_buf_if.snk in_if,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [3:0] out_data
);
    logic [3:0] m0_r, m0_nxt, m1_r, m1_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic vld_r, vld_nxt;

    // push, pop and occupancy
    always_comb
    begin
        push = in_if.valid && (cnt_r != 2'h2);
        pop = (cnt_r != 2'h0) && out_ready;
        m0_nxt = m0_r;
        m1_nxt = m1_r;
        cnt_nxt = cnt_r;
        if (pop)
        begin
            m0_nxt = m1_r;
        end
        if (push)
        begin
            if ((cnt_r == 2'h0) || (pop && cnt_r == 2'h1))
                m0_nxt = in_if.data;
            else if (pop)
                m1_nxt = in_if.data;
            else
                m1_nxt = in_if.data;
        end
        if (push && !pop)
            cnt_nxt = cnt_r + 2'h1;
        else if (pop && !push)
            cnt_nxt = cnt_r - 2'h1;
        vld_nxt = (cnt_nxt != 2'h0); // decided a cycle ahead for the flop
    end

    // register state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            m0_r <= 4'h0;
            m1_r <= 4'h0;
            cnt_r <= 2'h0;
            vld_r <= 1'b0;
        end
        else
        begin
            m0_r <= m0_nxt;
            m1_r <= m1_nxt;
            cnt_r <= cnt_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign in_if.ready = (cnt_r != 2'h2);
    assign out_valid = vld_r; // port taken straight from a flop
    assign out_data = m0_r;
endmodule // fbsr_skid
`default_nettype wire

/* dv/fbsr_chk.sv */
// port assertions for the four-bit shift register
`timescale 1ns/1ns
`default_nettype none
// ==========
// checker
module fbsr_chk
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // stage controls and data
    input wire logic stage_clk,
    input wire logic stage_clear,
    input wire logic load_sel,
    input wire logic true_sel,
    input wire logic [3:0] par_in,
    input wire logic serial_set,
    input wire logic serial_hold_n,
    // stage outputs and word stream
    input wire logic [3:0] stage_out,
    input wire logic first_stage_out,
    input wire logic last_stage_out,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic [3:0] word_data,
    // bus write answer, marks software steps and control changes
    input wire logic s_axi_bvalid
);
    logic jk_nxt;
    logic [2:0] body_nxt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // expected first stage and body after a shift
    assign jk_nxt = serial_set & ~stage_out[0] | serial_hold_n & stage_out[0];
    assign body_nxt = stage_out[2:0];
    // clean stage clock rise with room in the buffer
    sequence rise_s;
        stage_clk && !$past(stage_clk) && !stage_clear && !word_valid
            && true_sel && $past(true_sel) && $past(aresetn);
    endsequence
    // select flip while stages sit still
    sequence flip_s;
        !stage_clk && !$past(stage_clk) && !stage_clear
            && !$past(stage_clear) && $changed(true_sel) && $past(aresetn);
    endsequence
    tap_map_a: assert property (
        first_stage_out == stage_out[0] && last_stage_out == stage_out[3])
        else $error("stage taps differ");
    quiet_hold_a: assert property (
        !stage_clk && !stage_clear && $stable(true_sel) && $past(aresetn)
            && !s_axi_bvalid
        |=> $stable(stage_out)) else $error("stages moved");
    clear_force_a: assert property (
        stage_clear |=> stage_out == {4{!$past(true_sel)}})
        else $error("clear missed");
    polarity_flip_a: assert property (
        flip_s |=> stage_out == ~$past(stage_out))
        else $error("polarity wrong");
    par_load_a: assert property (
        rise_s ##0 load_sel |=> stage_out == $past(par_in))
        else $error("load wrong");
    shift_body_a: assert property (
        rise_s ##0 !load_sel |=> stage_out[3:1] == $past(body_nxt))
        else $error("shift wrong");
    first_jk_a: assert property (
        rise_s ##0 !load_sel |=> stage_out[0] == $past(jk_nxt))
        else $error("first stage wrong");
    word_hold_a: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("word dropped");
endmodule // fbsr_chk
bind fbsr_top fbsr_chk chk_u (.aclk, .aresetn, .stage_clk, .stage_clear,
    .load_sel, .true_sel, .par_in, .serial_set, .serial_hold_n, .stage_out,
    .first_stage_out, .last_stage_out, .word_valid, .word_ready, .word_data,
    .s_axi_bvalid);
`default_nettype wire

/* dv/fbsr_far.sv */
// surrounding logic: stage clock pulser and word sink
`timescale 1ns/1ns
`default_nettype none
// ==========
// far side
module fbsr_far
(
    // clock
    input wire logic aclk,
    // bench requests
    input wire logic go,
    input wire logic stall,
    // pins to the register
    output logic stage_clk,
    output logic word_ready
);
    // one-cycle pulse per request, low between steps
    always_ff @(posedge aclk)
        stage_clk <= go;
    // sink refuses words while stalled
    assign word_ready = !stall;
endmodule // fbsr_far
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the four-bit shift register
`timescale 1ns/1ns
`default_nettype none
`include "fbsr_consts.svh"
// ==========
// bench
module tb_top;
    logic aclk, aresetn, stage_clk, stage_clear, load_sel, true_sel, go;
    logic serial_set, serial_hold_n, stall, word_valid, word_ready;
    logic first_stage_out, last_stage_out;
    logic [3:0] par_in, stage_out, word_data, exp, s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [3:0] got_q[$], exp_q[$];
    int bad_count, samples_checked, seed, i;
    // 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    fbsr_top dut_u (.aclk, .aresetn, .stage_clk, .stage_clear, .load_sel,
        .true_sel, .par_in, .serial_set, .serial_hold_n, .stage_out,
        .first_stage_out, .last_stage_out, .word_valid, .word_ready,
        .word_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    fbsr_far far_u (.aclk, .go, .stall, .stage_clk, .word_ready);
    // collect words taken by the sink
    always @(posedge aclk)
        if (word_valid === 1'b1 && word_ready)
            got_q.push_back(word_data);
    // ==========
    // helpers
    function automatic logic [3:0] nxt(input logic [3:0] q,
        input logic ld, j, kn, input logic [3:0] d);
        nxt = ld ? d : {q[2:0], j & ~q[0] | kn & q[0]};
    endfunction
    task automatic chk4(input logic [3:0] got, input logic [3:0] want);
        samples_checked++;
        if (got !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: %h %h", $time, got, want);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: %h %h", $time, got, want);
        end
    endtask
    // one stage clock step; acc says whether room was left
    task automatic step(input logic ld, j, kn, acc);
        logic [3:0] d;
        d = 4'($random(seed));
        @(posedge aclk);
        par_in <= d;
        load_sel <= ld;
        serial_set <= j;
        serial_hold_n <= kn;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        if (acc)
        begin
            exp = nxt(exp, ld, j, kn, d);
            exp_q.push_back(exp);
        end
        chk4({last_stage_out, stage_out[2:1], first_stage_out}, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk32({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk32(s_axi_rdata, d);
        chk32({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========
    // scenarios
    initial
    begin
        seed = 98;
        {aresetn, stage_clear, load_sel, par_in, serial_set, go, stall} = '0;
        {true_sel, serial_hold_n, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        exp = 4'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk4(stage_out, exp);
        for (i = 0; i < 48; i++)
            step(i[2], i[1], i[0], 1'b1);
        repeat (6)
        begin
            @(posedge aclk);
            par_in <= 4'($random(seed));
            load_sel <= ~load_sel;
        end
        @(posedge aclk);
        true_sel <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk4(stage_out, ~exp);
        @(posedge aclk);
        true_sel <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk4(stage_out, exp);
        @(posedge aclk);
        stall <= 1'b1;
        step(1'b1, 1'b0, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge aclk);
        stall <= 1'b0;
        @(posedge aclk);
        stage_clear <= 1'b1;
        load_sel <= 1'b1;
        repeat (2) @(posedge aclk);
        stage_clear <= 1'b0;
        @(posedge aclk);
        #1;
        exp = 4'h0;
        chk4(stage_out, exp);
        step(1'b1, 1'b0, 1'b0, 1'b1);
        rd(`FBSR_ADDR_CTRL, {29'h0, `FBSR_CTRL_RST}, `FBSR_RESP_OKAY);
        wr(`FBSR_ADDR_CTRL, {29'h0, `FBSR_CTRL_RST}, `FBSR_RESP_OKAY);
        rd(`FBSR_ADDR_STAT, {28'h0, exp}, `FBSR_RESP_OKAY);
        rd(`FBSR_ADDR_STREAM, {28'h0, exp}, `FBSR_RESP_OKAY);
        wr(`FBSR_ADDR_CTRL, 32'h0, `FBSR_RESP_OKAY);
        rd(`FBSR_ADDR_STREAM, {28'h0, ~exp}, `FBSR_RESP_OKAY);
        rd(`FBSR_ADDR_STAT, {28'h0, exp}, `FBSR_RESP_OKAY);
        wr(`FBSR_ADDR_CTRL, {29'h0, `FBSR_CTRL_RST}, `FBSR_RESP_OKAY);
        exp = nxt(exp, 1'b1, 1'b0, 1'b0, 4'h9);
        exp_q.push_back(exp);
        wr(`FBSR_ADDR_PAR, 32'h9, `FBSR_RESP_OKAY);
        rd(`FBSR_ADDR_STAT, {28'h0, exp}, `FBSR_RESP_OKAY);
        rd(12'h010, 32'h0, `FBSR_RESP_SLVERR);
        wr(12'h010, 32'h5, `FBSR_RESP_SLVERR);
        chk32(32'(got_q.size()), 32'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            chk4(got_q.pop_front(), exp_q.pop_front());
        end_of_test();
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
